// file: pin_route_defs.svh
// Purpose: Offsets, field positions and reset values of the pin route registers
// Assumes: Byte-wide registers at byte offsets 0 to 5
// Notes: Definitions only
`ifndef PIN_ROUTE_DEFS_SVH
`define PIN_ROUTE_DEFS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_EVENT_OUTPUT_ROUTE 3'h0
`define OFS_LOGIC_TABLE_ROUTE 3'h1
`define OFS_ASYNC_SERIAL_ROUTE 3'h2
`define OFS_TWO_WIRE_SYNC_ROUTE 3'h3
`define OFS_TIMER_A_ROUTE 3'h4
`define OFS_TIMER_B_ROUTE 3'h5

// ----------------------------------------
// Implemented-bit masks and reset values
// ----------------------------------------
`define MASK_EVENT_OUTPUT_ROUTE 8'h3F
`define MASK_LOGIC_TABLE_ROUTE 8'h0F
`define MASK_ASYNC_SERIAL_ROUTE 8'hFF
`define MASK_TWO_WIRE_SYNC_ROUTE 8'h33
`define MASK_TIMER_A_ROUTE 8'h07
`define MASK_TIMER_B_ROUTE 8'h0F
`define ROUTE_RESET 8'h00

// ----------------------------------------
// Field positions
// ----------------------------------------
`define POS_TWO_WIRE 4
`define POS_SYNC_SERIAL 0

`endif

// file: pin_route_pkg.sv
// Purpose: Types shared by the pin route block
// Assumes: Nothing
// Notes: Codes of the multi-bit selects
package pin_route_pkg;

  // Register bus request
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_type;

  // Serial transceiver placement codes
  typedef enum logic [1:0] {
    SER_LOW = 2'h0,
    SER_HIGH = 2'h1,
    SER_RSVD = 2'h2,
    SER_NONE = 2'h3
  } serial_pos_type;

  // Decoded placement of all peripherals
  typedef struct packed {
    logic [5:0] event_out_alt;
    logic [5:0] event_out_en;
    logic [3:0] logic_table_alt;
    logic [3:0] serial_alt;
    logic [3:0] serial_en;
    logic [2:0] two_wire_port;
    logic [2:0] two_wire_slave_port;
    logic two_wire_en;
    logic [2:0] sync_serial_port;
    logic sync_serial_hi;
    logic sync_serial_en;
    logic [2:0] timer_a_port;
    logic timer_a_en;
    logic [3:0] timer_b_alt;
  } route_sel_type;

endpackage

// file: route_reg.sv
// Purpose: One byte-wide routing register with a write mask
// Assumes: Synchronous write strobe
// Notes: Bits outside the mask stay zero
`timescale 1ns/1ps
`include "pin_route_defs.svh"
module route_reg
  import pin_route_pkg::*;
#(
  parameter logic [7:0] MASK = 8'hFF
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Write side
  input wire logic we,
  input wire logic [7:0] wdata,
  // Stored value
  output logic [7:0] value_reg
);

  // Masked store; unused bits never take a one
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      value_reg <= `ROUTE_RESET;
    end else if (we) begin
      value_reg <= wdata & MASK;
    end
  end

endmodule

// file: peripheral_pin_route_select.sv
// Purpose: Pin route select registers for peripheral signals
// Assumes: Plain register port, read data one cycle after the read strobe
// Notes: Port codes 0..5 stand for ports A..F
//
// Behaviour
// - Event route register: six selects, bits 5:0
// - Events A, C, D: pin 2 or 7
// - Lookup tables: pin 3 or 6
// - Transceiver register: four two-bit fields
// - Codes: low, high, reserved, disconnected
// - Two-wire pair and slave port select
// - Synchronous serial placement or disconnect
// - Type-A timer port select, codes 0-5
// - Type-B timer 3: B5 or C1
// - Type-B timer 2: C0 or B4
// - All registers reset to zero
// - Timers 1, 0: A3/F5, A2/F4
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
`include "pin_route_defs.svh"
module peripheral_pin_route_select
  import pin_route_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Register port
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // Decoded routing
  output route_sel_type route,
  // Pin placement of type-B timer outputs, {port code, pin}
  output logic [5:0] timer_b_pin [4]
);

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  bus_req_type req;
  assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

  // One write enable per register
  wire [5:0] we_sel;
  assign we_sel[0] = req.wr && (req.addr == `OFS_EVENT_OUTPUT_ROUTE);
  assign we_sel[1] = req.wr && (req.addr == `OFS_LOGIC_TABLE_ROUTE);
  assign we_sel[2] = req.wr && (req.addr == `OFS_ASYNC_SERIAL_ROUTE);
  assign we_sel[3] = req.wr && (req.addr == `OFS_TWO_WIRE_SYNC_ROUTE);
  assign we_sel[4] = req.wr && (req.addr == `OFS_TIMER_A_ROUTE);
  assign we_sel[5] = req.wr && (req.addr == `OFS_TIMER_B_ROUTE);

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  logic [7:0] event_output_route_reg; // Event output selects
  logic [7:0] logic_table_route_reg; // Lookup-table selects
  logic [7:0] async_serial_route_reg; // Transceiver fields
  logic [7:0] two_wire_and_sync_serial_route_reg; // Two-wire and sync serial
  logic [7:0] timer_a_route_reg; // Type-A timer port
  logic [7:0] timer_b_route_reg; // Type-B timer selects

  // Reserved event codes are stored as written; the far side keeps them zero
  route_reg #(.MASK(`MASK_EVENT_OUTPUT_ROUTE)) u_event (
    .mclk(mclk), .rst(rst), .we(we_sel[0]), .wdata(req.wdata),
    .value_reg(event_output_route_reg)
  );
  route_reg #(.MASK(`MASK_LOGIC_TABLE_ROUTE)) u_table (
    .mclk(mclk), .rst(rst), .we(we_sel[1]), .wdata(req.wdata),
    .value_reg(logic_table_route_reg)
  );
  route_reg #(.MASK(`MASK_ASYNC_SERIAL_ROUTE)) u_serial (
    .mclk(mclk), .rst(rst), .we(we_sel[2]), .wdata(req.wdata),
    .value_reg(async_serial_route_reg)
  );
  route_reg #(.MASK(`MASK_TWO_WIRE_SYNC_ROUTE)) u_twsync (
    .mclk(mclk), .rst(rst), .we(we_sel[3]), .wdata(req.wdata),
    .value_reg(two_wire_and_sync_serial_route_reg)
  );
  route_reg #(.MASK(`MASK_TIMER_A_ROUTE)) u_timer_a (
    .mclk(mclk), .rst(rst), .we(we_sel[4]), .wdata(req.wdata),
    .value_reg(timer_a_route_reg)
  );
  route_reg #(.MASK(`MASK_TIMER_B_ROUTE)) u_timer_b (
    .mclk(mclk), .rst(rst), .we(we_sel[5]), .wdata(req.wdata),
    .value_reg(timer_b_route_reg)
  );

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  // Unmapped offsets answer zero rather than stale data
  logic [7:0] rdata_next;
  always_comb begin
    case (req.addr)
      `OFS_EVENT_OUTPUT_ROUTE: rdata_next = event_output_route_reg;
      `OFS_LOGIC_TABLE_ROUTE: rdata_next = logic_table_route_reg;
      `OFS_ASYNC_SERIAL_ROUTE: rdata_next = async_serial_route_reg;
      `OFS_TWO_WIRE_SYNC_ROUTE: rdata_next = two_wire_and_sync_serial_route_reg;
      `OFS_TIMER_A_ROUTE: rdata_next = timer_a_route_reg;
      `OFS_TIMER_B_ROUTE: rdata_next = timer_b_route_reg;
      default: rdata_next = 8'h00;
    endcase
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (req.rd) begin
      rdata <= rdata_next;
    end else begin
      rdata <= 8'h00;
    end
  end

  // ----------------------------------------
  // Field extraction
  // ----------------------------------------
  wire [1:0] two_wire_pos;
  wire [1:0] sync_serial_pos;
  wire [2:0] timer_a_port_sel;
  assign two_wire_pos = two_wire_and_sync_serial_route_reg[`POS_TWO_WIRE +: 2];
  assign sync_serial_pos = two_wire_and_sync_serial_route_reg[`POS_SYNC_SERIAL +: 2];
  assign timer_a_port_sel = timer_a_route_reg[2:0];

  // ----------------------------------------
  // Event outputs and lookup tables
  // ----------------------------------------
  // Alternate pin 7 only exists for A, C, D; B, E, F stay on pin 2
  assign route.event_out_alt = event_output_route_reg[5:0] & 6'h0D;
  // A reserved code on B, E or F parks the output off its pin
  assign route.event_out_en = ~(event_output_route_reg[5:0] & 6'h32);
  // Zero is pin 3, one is pin 6
  assign route.logic_table_alt = logic_table_route_reg[3:0];

  // ----------------------------------------
  // Serial transceivers
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_serial
      wire [1:0] code = async_serial_route_reg[2*gi +: 2];
      assign route.serial_alt[gi] = (code == SER_HIGH);
      // Reserved code is treated as disconnected so no pin sees it
      assign route.serial_en[gi] = (code == SER_LOW) || (code == SER_HIGH);
    end
  endgenerate

  // ----------------------------------------
  // Two-wire and synchronous serial
  // ----------------------------------------
  // Code 0: A with slave on C; 1: A with slave on F; 2: C with slave on F
  assign route.two_wire_port = (two_wire_pos == 2'h2) ? 3'h2 : 3'h0;
  assign route.two_wire_slave_port = (two_wire_pos == 2'h0) ? 3'h2 : 3'h5;
  assign route.two_wire_en = (two_wire_pos != 2'h3);

  // Code 0: A pins 7:4; 1: C pins 3:0; 2: E pins 3:0; 3: off
  // A continuous assignment, so the route struct keeps a single kind of driver
  assign route.sync_serial_port = (sync_serial_pos == 2'h1) ? 3'h2 :
                                  (sync_serial_pos == 2'h2) ? 3'h4 : 3'h0;
  assign route.sync_serial_hi = (sync_serial_pos == 2'h0);
  assign route.sync_serial_en = (sync_serial_pos != 2'h3);

  // ----------------------------------------
  // Timers
  // ----------------------------------------
  // Codes above five are reserved; the outputs are then left off
  assign route.timer_a_port = timer_a_port_sel;
  assign route.timer_a_en = (timer_a_port_sel <= 3'h5);
  assign route.timer_b_alt = timer_b_route_reg[3:0];

  // Type-B pin table {port, pin}: default and alternate for each timer
  assign timer_b_pin[0] = timer_b_route_reg[0] ? {3'h5, 3'h4} : {3'h0, 3'h2};
  assign timer_b_pin[1] = timer_b_route_reg[1] ? {3'h5, 3'h5} : {3'h0, 3'h3};
  assign timer_b_pin[2] = timer_b_route_reg[2] ? {3'h1, 3'h4} : {3'h2, 3'h0};
  assign timer_b_pin[3] = timer_b_route_reg[3] ? {3'h2, 3'h1} : {3'h1, 3'h5};

endmodule

// file: peripheral_pin_route_select_checker.sv
// Purpose: Port-level properties of the pin route block
// Assumes: One clock, reset active high
// Notes: Bound to the top module below
`timescale 1ns/1ps
module peripheral_pin_route_select_checker
  import pin_route_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Register port
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  // Routing outputs
  input wire route_sel_type route,
  input wire logic [5:0] timer_b_pin [4]
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // Read data only in the cycle after a read strobe
  a_rdata_idle_zero: assert property (rdata != 8'h00 |-> $past(rd))
    else $error("rdata nonzero without read");
  a_unmapped_read: assert property (rd && addr > 3'h5 |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_event_top_bits: assert property (rd && addr == 3'h0 |=> rdata[7:6] == 2'h0)
    else $error("event route top bits set");
  // Only outputs A, C and D have an alternate pin
  a_event_alt_pin: assert property (wr && addr == 3'h0 |=>
    {2'h0, route.event_out_alt} == ($past(wdata) & 8'h0D))
    else $error("event alternate wrong");
  a_table_alt_pin: assert property (wr && addr == 3'h1 |=>
    {4'h0, route.logic_table_alt} == ($past(wdata) & 8'h0F))
    else $error("lookup alternate wrong");
  a_serial3_enable: assert property (wr && addr == 3'h2 |=> route.serial_en[3] != $past(wdata[7]))
    else $error("serial 3 enable wrong");
  a_sync_serial_off: assert property (wr && addr == 3'h3 && wdata[1:0] == 2'h3 |=> !route.sync_serial_en)
    else $error("sync serial not off");
  a_timer_a_enable: assert property (wr && addr == 3'h4 |=> route.timer_a_en == ($past(wdata[2:0]) <= 3'h5))
    else $error("timer a enable wrong");
  a_timer_b2_pin: assert property (timer_b_pin[2] == (route.timer_b_alt[2] ? 6'h0C : 6'h10))
    else $error("timer b2 pin wrong");
  a_timer_b3_pin: assert property (timer_b_pin[3] == (route.timer_b_alt[3] ? 6'h11 : 6'h0D))
    else $error("timer b3 pin wrong");
  c_serial_write: cover property (wr && addr == 3'h2);
  c_unmapped_read: cover property (rd && addr > 3'h5);
  c_timer_a_rsvd: cover property (wr && addr == 3'h4 && wdata[2:0] > 3'h5);
endmodule

bind peripheral_pin_route_select peripheral_pin_route_select_checker peripheral_pin_route_select_checker_i (
  .mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .route(route), .timer_b_pin(timer_b_pin));

// file: peripheral_pin_route_select_bench.sv
// Purpose: Directed bench for the pin route block
// Assumes: Read data one cycle after the read strobe
// Notes: Pin codes are {port, pin}, ports A..F as 0..5
`timescale 1ns/1ps
module peripheral_pin_route_select_bench;
  import pin_route_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  route_sel_type route;
  logic [5:0] timer_b_pin [4];
  int fail_count = 0;
  int n_checks = 0;
  // Readable bits per offset; 6 and 7 are unmapped
  logic [7:0] mask [8] = '{8'h3F, 8'h0F, 8'hFF, 8'h33, 8'h07, 8'h0F, 8'h00, 8'h00};
  // Timer B pins, default and alternate
  logic [5:0] tb_def [4] = '{6'h02, 6'h03, 6'h10, 6'h0D};
  logic [5:0] tb_alt [4] = '{6'h2C, 6'h2D, 6'h0C, 6'h11};
  // Two-wire {port, slave} and sync serial {port, upper} per code
  logic [5:0] twi_exp [3] = '{6'h02, 6'h05, 6'h15};
  logic [3:0] spi_exp [3] = '{4'h1, 4'h4, 4'h8};
  always #20 mclk = ~mclk;
  peripheral_pin_route_select peripheral_pin_route_select_i (.mclk(mclk), .rst(rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .route(route), .timer_b_pin(timer_b_pin));
  task chk(input string n, input logic [7:0] e, input logic [7:0] s);
    n_checks++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr <= 1'b0;
    #1;
  endtask
  task rd_chk(input logic [2:0] a, input logic [7:0] e);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    chk("rdata", e, rdata);
  endtask
  // Reset values and default placement
  task t_reset;
    for (int a = 0; a < 6; a++)
      rd_chk(a[2:0], 8'h00);
    chk("tb_pin0", 8'h02, {2'h0, timer_b_pin[0]});
    chk("ta_en", 8'h01, {7'h0, route.timer_a_en});
  endtask
  // All ones to every offset: masks kept, reserved codes read back
  task t_masks;
    for (int a = 0; a < 8; a++) begin
      wr_reg(a[2:0], 8'hFF);
      rd_chk(a[2:0], mask[a]);
    end
    chk("ev_alt", 8'h0D, {2'h0, route.event_out_alt});
    chk("ev_en", 8'h0D, {2'h0, route.event_out_en});
  endtask
  // Write then read with no gap
  task t_b2b;
    @(posedge mclk);
    wr <= 1'b1;
    addr <= 3'h2;
    wdata <= 8'hC1;
    @(posedge mclk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    chk("rdata", 8'hC1, rdata);
    chk("ser_en", 8'h07, {4'h0, route.serial_en});
    chk("ser_alt", 8'h01, {4'h0, route.serial_alt});
    @(posedge mclk);
    #1;
    chk("rdata", 8'h00, rdata);
  endtask
  // Every code of the multi-bit fields
  task t_codes;
    logic [1:0] c;
    wr_reg(3'h0, 8'h0D);
    chk("ev_en", 8'h3F, {2'h0, route.event_out_en});
    chk("ev_alt", 8'h0D, {2'h0, route.event_out_alt});
    wr_reg(3'h1, 8'h05);
    chk("lut_alt", 8'h05, {4'h0, route.logic_table_alt});
    for (int i = 0; i < 4; i++) begin
      c = i[1:0];
      wr_reg(3'h2, {4{c}});
      chk("ser_en", (i < 2) ? 8'h0F : 8'h00, {4'h0, route.serial_en});
      chk("ser_alt", (i == 1) ? 8'h0F : 8'h00, {4'h0, route.serial_alt});
      wr_reg(3'h3, {2'h0, c, 2'h0, c});
      chk("twi_en", {7'h0, i < 3}, {7'h0, route.two_wire_en});
      chk("spi_en", {7'h0, i < 3}, {7'h0, route.sync_serial_en});
      if (i < 3) begin
        chk("twi", {2'h0, twi_exp[i]}, {2'h0, route.two_wire_port, route.two_wire_slave_port});
        chk("spi", {4'h0, spi_exp[i]}, {4'h0, route.sync_serial_port, route.sync_serial_hi});
      end
    end
    for (int i = 0; i < 8; i++) begin
      wr_reg(3'h4, i[7:0]);
      chk("ta_en", {7'h0, i < 6}, {7'h0, route.timer_a_en});
      if (i < 6)
        chk("ta_port", i[7:0], {5'h0, route.timer_a_port});
    end
  endtask
  // Timer B pins in two mixed patterns
  task t_timer_b;
    logic [3:0] v;
    for (int k = 0; k < 2; k++) begin
      v = k ? 4'h5 : 4'hA;
      wr_reg(3'h5, {4'h0, v});
      chk("tb_alt", {4'h0, v}, {4'h0, route.timer_b_alt});
      for (int i = 0; i < 4; i++)
        chk("tb_pin", {2'h0, v[i] ? tb_alt[i] : tb_def[i]}, {2'h0, timer_b_pin[i]});
    end
  endtask
  task finish_test;
    $display("checks %0d errors %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Watchdog, far beyond the hundred and ten or so cycles the run needs
  initial begin
    #100000;
    fail_count++;
    finish_test();
  end
  initial begin
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_masks();
    t_b2b();
    t_codes();
    t_timer_b();
    // Second reset in mid-run clears everything again
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    finish_test();
  end
endmodule
